// ### hdl/udec_pkg.sv
// constants, field layout and types of the usb endpoint control block
// assumes one AHB-Lite slave port and a packet engine on the same clock
// Overview of operation
// - data pins carry usb after reset; gpio use only when io config selects it
// - register side and bus side both on hclk; bus pin levels are resynchronised
// - one interrupt line, peripheral identifier 34
// - setup packet received sets setup flag; interrupt while it stays set
// - firmware clears setup flag by writing 0; a written 1 is ignored
// - while setup flag set, further OUT data on that endpoint is refused
// - iso crc error sets error flag with interrupt; write 0 clears it
// - tx ready set holds payload until IN token, sends, then clears flag
// - tx complete flag set once the host has received the IN payload
// - writing 0 to tx ready cancels a pending transmission
// - read-only data toggle per endpoint: 0 is DATA0, 1 is DATA1
// - enable bit write 1 enables, 0 disables; read returns state
// - control endpoints always enabled; enable bit has no effect there
// - after reset every endpoint has type code zero, control
// - read-only 11-bit count of bytes held in the endpoint fifo, received or queued to send
package udec_pkg;
	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0] OFS_ID = 8'h00;
	localparam logic [7:0] OFS_CSR0 = 8'h30;
	localparam logic [7:0] OFS_FDR0 = 8'h70;
	localparam logic [31:0] PERIPH_ID = 32'h0000_0022;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ***************************************************************
	// endpoint control and status fields
	// ***************************************************************
	localparam int CSR_TX_COMPLETE_FLAG = 0;
	localparam int CSR_RXDATA = 1;
	localparam int CSR_SETUP = 2;
	localparam int CSR_ISOERR = 3;
	localparam int CSR_TXRDY = 4;
	localparam int CSR_TYPE_LSB = 8;
	localparam int CSR_TOGGLE = 11;
	localparam int CSR_EPEN = 15;
	localparam int CSR_CNT_LSB = 16;
	localparam int CNT_W = 11;
	localparam int TYPE_W = 3;

	// ***************************************************************
	// endpoint type codes
	// ***************************************************************
	localparam logic [2:0] EPT_CTRL = 3'h0;
	localparam logic [2:0] EPT_ISO_OUT = 3'h1;
	localparam logic [2:0] EPT_BULK_OUT = 3'h2;
	localparam logic [2:0] EPT_INT_OUT = 3'h3;
	localparam logic [2:0] EPT_ISO_IN = 3'h5;
	localparam logic [2:0] EPT_BULK_IN = 3'h6;
	localparam logic [2:0] EPT_INT_IN = 3'h7;

	localparam int NUM_EP_DEF = 4;
	localparam int FIFO_DEPTH_DEF = 64;

	typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT} udec_tx_t;
endpackage

// ### hdl/udec_ep_fifo.sv
// one endpoint's byte fifo, shared by receive and transmit payloads
// ignores a push when full and a pop when empty
`timescale 1ns/1ps
module udec_ep_fifo #(
	parameter int DEPTH = udec_pkg::FIFO_DEPTH_DEF
) (
	input wire logic clk, // bus clock
	input wire logic rst_n, // async reset, low
	input wire logic ce, // clock enable
	input wire logic clr, // drop all content
	input wire logic push, // write one byte
	input wire logic [7:0] wdata, // byte to write
	input wire logic pop, // read one byte
	output logic [7:0] rdata, // byte at head
	output logic [udec_pkg::CNT_W-1:0] count, // bytes held
	output logic full, // no room
	output logic empty // nothing held
);
	import udec_pkg::*;
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || DEPTH > 1024 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("fifo depth must be a power of two from 2 to 1024");
	end

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} udec_fifo_t;

	udec_fifo_t r_reg, r_next;
	logic do_push, do_pop;

	assign full = r_reg.cnt == (AW+1)'(DEPTH);
	assign empty = r_reg.cnt == '0;
	assign rdata = r_reg.mem[r_reg.rp];
	assign count = CNT_W'(r_reg.cnt);

	always_comb begin
		r_next = r_reg;
		do_push = push && !full;
		do_pop = pop && !empty;
		if (clr) begin
			r_next.wp = '0;
			r_next.rp = '0;
			r_next.cnt = '0;
		end else begin
			if (do_push) begin
				r_next.mem[r_reg.wp] = wdata;
				r_next.wp = r_reg.wp + 1'b1;
			end
			if (do_pop) begin
				r_next.rp = r_reg.rp + 1'b1;
			end
			if (do_push && !do_pop) begin
				r_next.cnt = r_reg.cnt + 1'b1;
			end else if (do_pop && !do_push) begin
				r_next.cnt = r_reg.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end
endmodule // udec_ep_fifo

// ### hdl/udec_endpoint_ctrl.sv
// endpoint control and status with AHB-Lite register access
// assumes a packet engine on hclk that decodes tokens and checks crc
`timescale 1ns/1ps
module udec_endpoint_ctrl #(
	parameter int NUM_EP = udec_pkg::NUM_EP_DEF,
	parameter int FIFO_DEPTH = udec_pkg::FIFO_DEPTH_DEF,
	localparam int EPW = $clog2(NUM_EP)
) (
	input wire logic hclk, // bus clock, 25 MHz
	input wire logic hresetn, // async reset, low
	input wire logic ce, // clock enable
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write access
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	output logic irq, // interrupt, high
	input wire logic lk_rx_valid, // received byte present
	input wire logic [EPW-1:0] lk_rx_ep, // endpoint of rx packet
	input wire logic [7:0] lk_rx_byte, // received byte
	input wire logic lk_rx_setup, // rx packet is a setup
	output logic lk_rx_ready, // byte accepted
	input wire logic lk_rx_end, // end of rx packet
	input wire logic lk_rx_crc_ok, // crc good at end
	input wire logic lk_in_token, // IN token pulse
	input wire logic [EPW-1:0] lk_in_ep, // endpoint of IN token
	output logic lk_in_has_data, // payload ready to send
	output logic lk_tx_valid, // tx byte present
	output logic [7:0] lk_tx_byte, // tx byte
	output logic lk_tx_last, // last tx byte
	input wire logic lk_tx_ready, // engine takes byte
	input wire logic lk_host_ack, // host acknowledged IN
	input wire logic usb_data_plus_i, // pin level
	output logic usb_data_plus_o, // pin drive value
	output logic usb_data_plus_oe_n, // pin enable, low drives
	input wire logic usb_data_minus_i, // pin level
	output logic usb_data_minus_o, // pin drive value
	output logic usb_data_minus_oe_n, // pin enable, low drives
	input wire logic se_dp_o, // engine plus drive
	input wire logic se_dm_o, // engine minus drive
	input wire logic se_drive, // engine drives pair
	output logic usb_dp_rx, // synced plus level
	output logic usb_dm_rx, // synced minus level
	input wire logic system_io_config_gpio, // pins used as gpio
	input wire logic gpio_dp_o, // gpio plus value
	input wire logic gpio_dm_o, // gpio minus value
	input wire logic gpio_oe // gpio drives pins
);
	import udec_pkg::*;

	if (NUM_EP < 2 || NUM_EP > 16) begin : g_chk
		$error("endpoint count must be 2 to 16");
	end

	// ***************************************************************
	// state
	// ***************************************************************
	typedef struct packed {
		logic ph_valid;
		logic ph_write;
		logic [7:0] ph_addr;
		logic rd_done;
		logic [31:0] rdata;
		logic [NUM_EP-1:0] tx_complete_flag;
		logic [NUM_EP-1:0] rxdata;
		logic [NUM_EP-1:0] setup;
		logic [NUM_EP-1:0] isoerr;
		logic [NUM_EP-1:0] txrdy;
		logic [NUM_EP-1:0] toggle;
		logic [NUM_EP-1:0] en;
		logic [NUM_EP-1:0][TYPE_W-1:0] eptype;
		udec_tx_t tx_st;
		logic [EPW-1:0] tx_ep;
		logic dp_s1;
		logic dp_s2;
		logic dm_s1;
		logic dm_s2;
	} udec_state_t;

	udec_state_t r_reg, r_next;

	logic [NUM_EP-1:0] f_push, f_pop, f_clr, f_full, f_empty, en_eff;
	logic [NUM_EP-1:0] cancel;
	logic [NUM_EP-1:0][7:0] f_wdata, f_rdata;
	logic [NUM_EP-1:0][CNT_W-1:0] f_cnt;
	logic [NUM_EP-1:0][31:0] csr_word;
	logic ap_take, rd_now, wr_now, rx_take;

	function automatic logic win_hit(input logic [7:0] a,
			input logic [7:0] base);
		return a >= base && a < base + 8'(4 * NUM_EP) && a[1:0] == 2'h0;
	endfunction

	function automatic logic [EPW-1:0] win_idx(input logic [7:0] a,
			input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return EPW'(d[7:2]);
	endfunction

	function automatic logic is_iso(input logic [TYPE_W-1:0] t);
		return t == EPT_ISO_OUT || t == EPT_ISO_IN;
	endfunction

	// ***************************************************************
	// endpoint fifos
	// ***************************************************************
	for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
		udec_ep_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
			.clk(hclk),
			.rst_n(hresetn),
			.ce(ce),
			.clr(f_clr[i]),
			.push(f_push[i]),
			.wdata(f_wdata[i]),
			.pop(f_pop[i]),
			.rdata(f_rdata[i]),
			.count(f_cnt[i]),
			.full(f_full[i]),
			.empty(f_empty[i])
		);
		// control endpoints cannot be switched off
		assign en_eff[i] = r_reg.eptype[i] == EPT_CTRL || r_reg.en[i];
		always_comb begin
			csr_word[i] = WORD_ZERO;
			csr_word[i][CSR_TX_COMPLETE_FLAG] = r_reg.tx_complete_flag[i];
			csr_word[i][CSR_RXDATA] = r_reg.rxdata[i];
			csr_word[i][CSR_SETUP] = r_reg.setup[i];
			csr_word[i][CSR_ISOERR] = r_reg.isoerr[i];
			csr_word[i][CSR_TXRDY] = r_reg.txrdy[i];
			csr_word[i][CSR_TYPE_LSB+:TYPE_W] = r_reg.eptype[i];
			csr_word[i][CSR_TOGGLE] = r_reg.toggle[i];
			csr_word[i][CSR_EPEN] = en_eff[i];
			csr_word[i][CSR_CNT_LSB+:CNT_W] = f_cnt[i];
		end
	end

	// ***************************************************************
	// pins and outputs
	// ***************************************************************
	// io config low after reset keeps the pair on the usb engine
	assign usb_data_plus_o = system_io_config_gpio ? gpio_dp_o : se_dp_o;
	assign usb_data_minus_o = system_io_config_gpio ? gpio_dm_o : se_dm_o;
	assign usb_data_plus_oe_n =
		!(system_io_config_gpio ? gpio_oe : se_drive);
	assign usb_data_minus_oe_n = usb_data_plus_oe_n;
	// bus-side levels are resynchronised before the engine sees them
	assign usb_dp_rx = r_reg.dp_s2;
	assign usb_dm_rx = r_reg.dm_s2;

	assign rd_now = r_reg.ph_valid && !r_reg.ph_write && !r_reg.rd_done;
	assign wr_now = r_reg.ph_valid && r_reg.ph_write;
	assign ap_take = hsel && hready && htrans[1];
	assign hreadyout = !rd_now;
	assign hresp = 1'b0;
	assign hrdata = r_reg.rdata;
	// level interrupt: stays up while any event flag is set
	assign irq = |(r_reg.setup | r_reg.isoerr | r_reg.tx_complete_flag
		| r_reg.rxdata);

	// a pending setup blocks later OUT data until firmware clears it
	assign lk_rx_ready = en_eff[lk_rx_ep] && !f_full[lk_rx_ep]
		&& (lk_rx_setup || (!r_reg.setup[lk_rx_ep]
		&& !r_reg.rxdata[lk_rx_ep]));
	assign rx_take = lk_rx_valid && lk_rx_ready;
	assign lk_in_has_data = r_reg.tx_st == TX_IDLE
		&& r_reg.txrdy[lk_in_ep] && en_eff[lk_in_ep];
	assign lk_tx_valid = r_reg.tx_st == TX_SEND && !f_empty[r_reg.tx_ep];
	assign lk_tx_byte = f_rdata[r_reg.tx_ep];
	assign lk_tx_last = lk_tx_valid && f_cnt[r_reg.tx_ep] == CNT_W'(1);

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb begin
		logic [EPW-1:0] k;
		k = '0;
		r_next = r_reg;
		f_push = '0;
		f_pop = '0;
		f_clr = '0;
		f_wdata = '0;
		cancel = '0;
		r_next.dp_s1 = usb_data_plus_i;
		r_next.dp_s2 = r_reg.dp_s1;
		r_next.dm_s1 = usb_data_minus_i;
		r_next.dm_s2 = r_reg.dm_s1;

		// register read: one wait state so hrdata comes from a flop
		if (rd_now) begin
			r_next.rd_done = 1'b1;
			r_next.rdata = WORD_ZERO;
			if (r_reg.ph_addr == OFS_ID) begin
				r_next.rdata = PERIPH_ID;
			end else if (win_hit(r_reg.ph_addr, OFS_CSR0)) begin
				r_next.rdata = csr_word[win_idx(r_reg.ph_addr, OFS_CSR0)];
			end else if (win_hit(r_reg.ph_addr, OFS_FDR0)) begin
				k = win_idx(r_reg.ph_addr, OFS_FDR0);
				r_next.rdata[7:0] = f_rdata[k];
				f_pop[k] = 1'b1;
			end
		end

		// register write: clears first so hardware sets below win
		if (wr_now && win_hit(r_reg.ph_addr, OFS_CSR0)) begin
			k = win_idx(r_reg.ph_addr, OFS_CSR0);
			if (!hwdata[CSR_TX_COMPLETE_FLAG]) begin
				r_next.tx_complete_flag[k] = 1'b0;
			end
			if (!hwdata[CSR_RXDATA]) begin
				r_next.rxdata[k] = 1'b0;
			end
			if (!hwdata[CSR_SETUP]) begin
				r_next.setup[k] = 1'b0;
			end
			if (!hwdata[CSR_ISOERR]) begin
				r_next.isoerr[k] = 1'b0;
			end
			if (!hwdata[CSR_TXRDY] && r_reg.txrdy[k]) begin
				cancel[k] = 1'b1;
			end
			if (r_reg.eptype[k] != EPT_CTRL) begin
				r_next.en[k] = hwdata[CSR_EPEN];
			end
			r_next.eptype[k] = hwdata[CSR_TYPE_LSB+:TYPE_W];
		end
		if (wr_now && win_hit(r_reg.ph_addr, OFS_FDR0)) begin
			k = win_idx(r_reg.ph_addr, OFS_FDR0);
			// link receive owns the fifo port when both hit one endpoint
			if (!(rx_take && lk_rx_ep == k)) begin
				f_push[k] = 1'b1;
				f_wdata[k] = hwdata[7:0];
			end
		end

		// address phase
		if (hreadyout) begin
			r_next.ph_valid = ap_take;
			if (ap_take) begin
				r_next.ph_write = hwrite;
				r_next.ph_addr = haddr[7:0];
				r_next.rd_done = 1'b0;
			end
		end

		// receive path
		if (rx_take) begin
			f_push[lk_rx_ep] = 1'b1;
			f_wdata[lk_rx_ep] = lk_rx_byte;
		end
		if (lk_rx_end) begin
			if (lk_rx_crc_ok) begin
				if (lk_rx_setup) begin
					r_next.setup[lk_rx_ep] = 1'b1;
					r_next.toggle[lk_rx_ep] = 1'b0;
				end else begin
					r_next.rxdata[lk_rx_ep] = 1'b1;
					if (!is_iso(r_reg.eptype[lk_rx_ep])) begin
						r_next.toggle[lk_rx_ep] = !r_reg.toggle[lk_rx_ep];
					end
				end
			end else if (is_iso(r_reg.eptype[lk_rx_ep])) begin
				// data stays in the fifo but is marked corrupt
				r_next.isoerr[lk_rx_ep] = 1'b1;
				r_next.rxdata[lk_rx_ep] = 1'b1;
			end else begin
				f_clr[lk_rx_ep] = 1'b1;
			end
		end

		// transmit path
		case (r_reg.tx_st)
			TX_IDLE: begin
				if (lk_in_token && lk_in_has_data) begin
					r_next.tx_st = TX_SEND;
					r_next.tx_ep = lk_in_ep;
				end
			end
			TX_SEND: begin
				if (lk_tx_valid && lk_tx_ready) begin
					f_pop[r_reg.tx_ep] = 1'b1;
				end
				if (f_empty[r_reg.tx_ep] || (lk_tx_last && lk_tx_ready)) begin
					r_next.txrdy[r_reg.tx_ep] = 1'b0;
					r_next.tx_st = TX_WAIT;
				end
			end
			TX_WAIT: begin
				if (lk_host_ack) begin
					r_next.tx_complete_flag[r_reg.tx_ep] = 1'b1;
					r_next.toggle[r_reg.tx_ep] = !r_reg.toggle[r_reg.tx_ep];
					r_next.tx_st = TX_IDLE;
				end
			end
			default: begin
				r_next.tx_st = TX_IDLE;
			end
		endcase

		// firmware cancel and arm come last so they take priority
		for (int i = 0; i < NUM_EP; i++) begin
			if (cancel[i]) begin
				r_next.txrdy[i] = 1'b0;
				f_clr[i] = 1'b1;
				f_pop[i] = 1'b0;
				if (r_reg.tx_ep == EPW'(i) && r_reg.tx_st != TX_IDLE) begin
					r_next.tx_st = TX_IDLE;
				end
			end
		end
		if (wr_now && win_hit(r_reg.ph_addr, OFS_CSR0)
				&& hwdata[CSR_TXRDY]) begin
			r_next.txrdy[win_idx(r_reg.ph_addr, OFS_CSR0)] = 1'b1;
		end
	end

	// reset clears everything, so all endpoints start as control type
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// ***************************************************************
	// checks
	// ***************************************************************
	logic csr0_wr, csr_wr;
	logic [EPW-1:0] wr_ep;
	assign csr0_wr = wr_now && r_reg.ph_addr == OFS_CSR0;
	assign csr_wr = wr_now && win_hit(r_reg.ph_addr, OFS_CSR0);
	assign wr_ep = win_idx(r_reg.ph_addr, OFS_CSR0);

	sequence s_arm;
		ce && csr_wr && hwdata[CSR_TXRDY] && !r_reg.txrdy[wr_ep];
	endsequence
	sequence s_cancel;
		ce && csr_wr && !hwdata[CSR_TXRDY] && r_reg.txrdy[wr_ep];
	endsequence

	property p_setup_irq;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.setup[0] |-> irq;
	endproperty
	a_setup_irq: assert property (p_setup_irq) else $error("no irq");

	property p_setup_w1;
		@(posedge hclk) disable iff (!hresetn)
		ce && csr0_wr && hwdata[CSR_SETUP] && r_reg.setup[0]
			|=> r_reg.setup[0];
	endproperty
	a_setup_w1: assert property (p_setup_w1) else $error("w1 cleared");

	property p_refuse_out;
		@(posedge hclk) disable iff (!hresetn)
		lk_rx_valid && !lk_rx_setup && r_reg.setup[lk_rx_ep] |-> !lk_rx_ready;
	endproperty
	a_refuse_out: assert property (p_refuse_out) else $error("out taken");

	property p_iso_err;
		@(posedge hclk) disable iff (!hresetn)
		ce && lk_rx_end && !lk_rx_crc_ok && is_iso(r_reg.eptype[lk_rx_ep])
			|=> r_reg.isoerr[$past(lk_rx_ep)] && irq;
	endproperty
	a_iso_err: assert property (p_iso_err) else $error("iso flag");

	property p_tx_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_arm ##1 (!lk_in_token && cancel == '0)[*3]
			|-> r_reg.txrdy[$past(wr_ep, 3)];
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");

	property p_tx_comp;
		@(posedge hclk) disable iff (!hresetn)
		ce && r_reg.tx_st == TX_WAIT && lk_host_ack
			|=> r_reg.tx_complete_flag[$past(r_reg.tx_ep)] && r_reg.tx_st == TX_IDLE;
	endproperty
	a_tx_comp: assert property (p_tx_comp) else $error("no tx_complete_flag");

	property p_cancel;
		@(posedge hclk) disable iff (!hresetn)
		s_cancel |=> !r_reg.txrdy[$past(wr_ep)] && f_empty[$past(wr_ep)];
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel ignored");

	property p_ctrl_en;
		@(posedge hclk) disable iff (!hresetn)
		r_reg.eptype[1] == EPT_CTRL |-> csr_word[1][CSR_EPEN];
	endproperty
	a_ctrl_en: assert property (p_ctrl_en) else $error("ctrl off");

	property p_fdr_pop;
		@(posedge hclk) disable iff (!hresetn)
		ce && rd_now && r_reg.ph_addr == OFS_FDR0 && !f_empty[0]
			&& !(rx_take && lk_rx_ep == '0) && !f_clr[0]
			|=> f_cnt[0] == $past(f_cnt[0]) - CNT_W'(1);
	endproperty
	a_fdr_pop: assert property (p_fdr_pop) else $error("pop count");
endmodule // udec_endpoint_ctrl

// ### verification/udec_host_model.sv
// host and packet engine stand-in for the endpoint link side
// assumes the bench calls its tasks just after a rising hclk edge
`timescale 1ns/1ps
module udec_host_model #(
	parameter int EW = 2
) (
	input wire logic hclk, // bus clock
	input wire logic lk_rx_ready, // byte accepted
	input wire logic lk_in_has_data, // payload pending
	input wire logic lk_tx_valid, // tx byte present
	input wire logic [7:0] lk_tx_byte, // tx byte
	input wire logic lk_tx_last, // last tx byte
	output logic lk_rx_valid, // byte present
	output logic [EW-1:0] lk_rx_ep, // rx endpoint
	output logic [7:0] lk_rx_byte, // rx byte
	output logic lk_rx_setup, // setup packet
	output logic lk_rx_end, // packet end
	output logic lk_rx_crc_ok, // crc result
	output logic lk_in_token, // IN token
	output logic [EW-1:0] lk_in_ep, // IN endpoint
	output logic lk_tx_ready, // takes tx byte
	output logic lk_host_ack, // host ack
	output logic seen_v, // host got a byte
	output logic [7:0] seen_b // that byte
);
	// *****
	// packet tasks
	// *****
	int timeouts;

	initial begin
		{lk_rx_valid, lk_rx_setup, lk_rx_end, lk_rx_crc_ok} = '0;
		{lk_in_token, lk_tx_ready, lk_host_ack, seen_v} = '0;
		lk_rx_ep = '0;
		lk_in_ep = '0;
		lk_rx_byte = 8'h00;
		seen_b = 8'h00;
		timeouts = 0;
	end

	task automatic hdr(input logic [EW-1:0] ep, input logic su);
		lk_rx_ep <= ep;
		lk_rx_setup <= su;
	endtask

	task automatic sel_in(input logic [EW-1:0] ep);
		lk_in_ep <= ep;
	endtask

	task automatic send(input logic [EW-1:0] ep, input logic su,
		input logic ok, input logic [7:0] b[$]);
		int n;
		hdr(ep, su);
		foreach (b[i]) begin
			lk_rx_valid <= 1'b1;
			lk_rx_byte <= b[i];
			n = 0;
			do begin
				@(posedge hclk);
				n++;
			end while (lk_rx_ready !== 1'b1 && n < 40);
			if (lk_rx_ready !== 1'b1)
				timeouts++;
		end
		// released data line shows garbage, not the last byte
		lk_rx_valid <= 1'b0;
		lk_rx_byte <= ~lk_rx_byte;
		lk_rx_end <= 1'b1;
		lk_rx_crc_ok <= ok;
		@(posedge hclk);
		lk_rx_end <= 1'b0;
		lk_rx_crc_ok <= ~ok;
		@(posedge hclk);
	endtask

	task automatic in_tok(input logic [EW-1:0] ep);
		int n;
		logic go;
		lk_in_token <= 1'b1;
		lk_in_ep <= ep;
		@(posedge hclk);
		go = lk_in_has_data;
		lk_in_token <= 1'b0;
		n = 0;
		while (go && n < 60) begin
			lk_tx_ready <= 1'($urandom);
			@(posedge hclk);
			n++;
			seen_v <= lk_tx_valid && lk_tx_ready;
			seen_b <= lk_tx_byte;
			if (lk_tx_valid && lk_tx_ready && lk_tx_last)
				go = 1'b0;
		end
		if (go)
			timeouts++;
		lk_tx_ready <= 1'b0;
		@(posedge hclk);
		seen_v <= 1'b0;
		// ack only after the whole payload arrived
		lk_host_ack <= !go && lk_in_has_data !== 1'bx && n > 0;
		@(posedge hclk);
		lk_host_ack <= 1'b0;
		@(posedge hclk);
	endtask
endmodule // udec_host_model

// ### verification/usb_device_endpoint_control_tb.sv
// self-checking bench: AHB-Lite firmware side plus host model
// assumes hready is the one slave's hreadyout
`timescale 1ns/1ps
module usb_device_endpoint_control_tb;
	import udec_pkg::*;
	logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic lk_rx_valid, lk_rx_setup, lk_rx_ready, lk_rx_end, lk_rx_crc_ok;
	logic lk_in_token, lk_in_has_data, lk_tx_valid, lk_tx_last;
	logic lk_tx_ready, lk_host_ack, seen_v, rd_ph;
	logic [1:0] lk_rx_ep, lk_in_ep;
	logic [7:0] lk_rx_byte, lk_tx_byte, seen_b, t;
	logic usb_data_plus_i, usb_data_plus_o, usb_data_plus_oe_n;
	logic usb_data_minus_i, usb_data_minus_o, usb_data_minus_oe_n;
	logic se_dp_o, se_dm_o, se_drive, usb_dp_rx, usb_dm_rx;
	logic system_io_config_gpio, gpio_dp_o, gpio_dm_o, gpio_oe;
	logic [63:0] e;
	logic [7:0] q[$], txq[$];
	logic [63:0] rdq[$];
	int num_errors, cmp_count;

	udec_endpoint_ctrl #(.NUM_EP(4), .FIFO_DEPTH(64)) u_dut (
		.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq,
		.lk_rx_valid, .lk_rx_ep, .lk_rx_byte, .lk_rx_setup, .lk_rx_ready,
		.lk_rx_end, .lk_rx_crc_ok, .lk_in_token, .lk_in_ep,
		.lk_in_has_data, .lk_tx_valid, .lk_tx_byte, .lk_tx_last,
		.lk_tx_ready, .lk_host_ack, .usb_data_plus_i, .usb_data_plus_o,
		.usb_data_plus_oe_n, .usb_data_minus_i, .usb_data_minus_o,
		.usb_data_minus_oe_n, .se_dp_o, .se_dm_o, .se_drive, .usb_dp_rx,
		.usb_dm_rx, .system_io_config_gpio, .gpio_dp_o, .gpio_dm_o, .gpio_oe
	);

	udec_host_model #(.EW(2)) u_host (
		.hclk, .lk_rx_ready, .lk_in_has_data, .lk_tx_valid, .lk_tx_byte,
		.lk_tx_last, .lk_rx_valid, .lk_rx_ep, .lk_rx_byte, .lk_rx_setup,
		.lk_rx_end, .lk_rx_crc_ok, .lk_in_token, .lk_in_ep, .lk_tx_ready,
		.lk_host_ack, .seen_v, .seen_b
	);

	// *****
	// checking and bus tasks
	// *****
	// the usb-side engine is modelled on hclk; its clock source is outside
	always #20 hclk = ~hclk;

	task automatic test_done();
		num_errors += u_host.timeouts;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, x, g);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin
			num_errors++;
			test_done();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic [31:0] m);
		rdq.push_back({m, x});
		ahb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic pins(input logic g);
		repeat (4) begin
			system_io_config_gpio <= g;
			{usb_data_plus_i, usb_data_minus_i, se_dp_o, se_dm_o, se_drive,
				gpio_dp_o, gpio_dm_o, gpio_oe} <= 8'($urandom);
			repeat (3) @(posedge hclk);
			#1;
			chk("dp_o", g ? gpio_dp_o : se_dp_o, usb_data_plus_o);
			chk("dm_o", g ? gpio_dm_o : se_dm_o, usb_data_minus_o);
			chk("dp_oe_n", !(g ? gpio_oe : se_drive), usb_data_plus_oe_n);
			chk("dp_rx", usb_data_plus_i, usb_dp_rx);
			chk("dm_oe_n", !(g ? gpio_oe : se_drive),
				usb_data_minus_oe_n);
			chk("dm_rx", usb_data_minus_i, usb_dm_rx);
		end
	endtask

	// results appear here; the oldest note is taken off its queue
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			e = rdq.pop_front();
			chk("hrdata", e[31:0], hrdata & e[63:32]);
			chk("hresp", 0, hresp);
		end
		if (hreadyout === 1'b1)
			rd_ph <= hsel && htrans[1] && !hwrite;
		if (seen_v)
			chk("tx_byte", txq.size() > 0 ? {24'h00_0000, txq.pop_front()}
				: 32'hFFFF_FFFF, {24'h00_0000, seen_b});
	end

	initial begin
		#400_000;
		num_errors++;
		test_done();
	end

	// *****
	// scenarios
	// *****
	initial begin
		{hclk, hresetn, hsel, hwrite, rd_ph, ce} = 6'b00_0001;
		{htrans, hsize, haddr, hwdata} = {5'h02, 64'h0};
		{usb_data_plus_i, usb_data_minus_i, se_dp_o, se_dm_o} = '0;
		{se_drive, system_io_config_gpio, gpio_dp_o, gpio_dm_o} = '0;
		gpio_oe = 1'b0;
		void'($urandom(93474));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		pins(1'b0);
		pins(1'b1);
		system_io_config_gpio <= 1'b0;
		@(posedge hclk);
		rd(OFS_ID, PERIPH_ID, '1);
		rd(8'h20, WORD_ZERO, '1);
		for (int i = 0; i < 4; i++)
			rd(OFS_CSR0 + 8'(4 * i), 32'h0000_8000, '1);
		q = {8'($urandom), 8'($urandom)};
		u_host.send(2'd0, 1'b1, 1'b1, q);
		#1 chk("irq", 1, irq);
		rd(OFS_CSR0, 32'h0002_8004, '1);
		u_host.hdr(2'd0, 1'b0);
		@(posedge hclk);
		#1 chk("rx_ready", 0, lk_rx_ready);
		ahb(1'b1, OFS_CSR0, 32'h0000_8004);
		rd(OFS_CSR0, 32'h0002_8004, '1);
		foreach (q[i])
			rd(OFS_FDR0, {24'h00_0000, q[i]}, '1);
		rd(OFS_CSR0, 32'h0000_8004, '1);
		ahb(1'b1, OFS_CSR0, 32'h0000_0000);
		rd(OFS_CSR0, 32'h0000_8000, '1);
		#1 chk("irq", 0, irq);
		chk("rx_ready", 1, lk_rx_ready);
		ahb(1'b1, OFS_CSR0 + 8'h04, 32'h0000_0200);
		rd(OFS_CSR0 + 8'h04, 32'h0000_0200, '1);
		ahb(1'b1, OFS_CSR0 + 8'h04, 32'h0000_8100);
		rd(OFS_CSR0 + 8'h04, 32'h0000_8100, '1);
		q = {8'($urandom)};
		u_host.send(2'd1, 1'b0, 1'b0, q);
		rd(OFS_CSR0 + 8'h04, 32'h0001_810A, '1);
		#1 chk("irq", 1, irq);
		ahb(1'b1, OFS_CSR0 + 8'h04, 32'h0000_810A);
		rd(OFS_CSR0 + 8'h04, 32'h0001_810A, '1);
		ahb(1'b1, OFS_CSR0 + 8'h04, 32'h0000_8100);
		rd(OFS_CSR0 + 8'h04, 32'h0000_8100, 32'h0000_FFFF);
		#1 chk("irq", 0, irq);
		ahb(1'b1, OFS_CSR0 + 8'h08, 32'h0000_8600);
		rd(OFS_CSR0 + 8'h08, 32'h0000_0000, 32'h0000_0010);
		for (int i = 0; i < 3; i++) begin
			t = 8'($urandom);
			txq.push_back(t);
			ahb(1'b1, OFS_FDR0 + 8'h08, {24'h00_0000, t});
		end
		ahb(1'b1, OFS_CSR0 + 8'h08, 32'h0000_8610);
		repeat (6) @(posedge hclk);
		rd(OFS_CSR0 + 8'h08, 32'h0000_8610, 32'h0000_FFFF);
		u_host.sel_in(2'd2);
		#1 chk("in_has_data", 1, lk_in_has_data);
		u_host.in_tok(2'd2);
		rd(OFS_CSR0 + 8'h08, 32'h0000_8E01, 32'h0000_FFFF);
		chk("tx_left", 0, txq.size());
		ahb(1'b1, OFS_CSR0 + 8'h08, 32'h0000_8600);
		rd(OFS_CSR0 + 8'h08, 32'h0000_8E00, 32'h0000_FFFF);
		ahb(1'b1, OFS_FDR0 + 8'h08, {24'h00_0000, 8'($urandom)});
		ahb(1'b1, OFS_CSR0 + 8'h08, 32'h0000_8610);
		repeat (6) @(posedge hclk);
		ahb(1'b1, OFS_CSR0 + 8'h08, 32'h0000_8600);
		repeat (6) @(posedge hclk);
		rd(OFS_CSR0 + 8'h08, 32'h0000_8E00, '1);
		#1 chk("in_has_data", 0, lk_in_has_data);
		u_host.in_tok(2'd2);
		// engine stops driving the pair: transceiver output enable must be released
		se_drive <= 1'b0;
		@(posedge hclk);
		#1 chk("oe_off", 1, usb_data_plus_oe_n);
		test_done();
	end
endmodule // usb_device_endpoint_control_tb
